// [adc_device.sv]
`timescale 1ns/1ns
// Converter end: conversion timing, serial readout, calibration and standby
module adc_device
    import adc_link_pkg::*;
#(
    parameter int CONV_FAST = CONV_FAST_CYC,
    parameter int CONV_SLOW = CONV_SLOW_CYC,
    parameter int CAL_FAST  = CAL_FAST_CYC,
    parameter int CAL_SLOW  = CAL_SLOW_CYC,
    parameter int STBY_FAST = STBY_FAST_CYC,
    parameter int STBY_SLOW = STBY_SLOW_CYC,
    parameter int WAKE_FAST = WAKE_FAST_CYC,
    parameter int WAKE_SLOW = WAKE_SLOW_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    adc_link_if.dev                link,
    input  wire logic              rate_fast,
    input  wire logic signed [31:0] sample_in,
    output logic                   cal_active,
    output logic                   analog_on
);
    // Wake-up settling reuses the calibration state: both keep the
    // inputs off and end with a fully settled result
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_CAL  = 2'b01,
        ST_STBY = 2'b10
    } dev_state_t;

    dev_state_t              state_r;
    logic [CNT_W-1:0]        conv_cnt_r;
    logic [CNT_W-1:0]        high_cnt_r;
    logic [DATA_W-1:0]       shreg_r;
    logic [5:0]              bit_cnt_r;
    logic                    dout_r;
    logic                    rate_r;
    logic                    sclk_lvl;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic [CNT_W-1:0]        period;
    logic [CNT_W-1:0]        stby_lim;
    logic                    conv_done;
    logic                    update_win;
    logic [DATA_W-1:0]       clipped;
    // Readout strobes
    logic                    load_result;
    logic                    hold_end;
    logic                    shift_step;
    logic                    in_data;

    // Shift clock edges act three ref_clk cycles after the pin moves;
    // the host must keep each half period at least that long
    sync_edge i_sync_edge (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     (link.shift_clk),
        .level   (sclk_lvl),
        .rise    (sclk_rise),
        .fall    (sclk_fall)
    );

    // Rate pin sampled through two flops as well
    // A rate change sets the period at the next result reload, the standby limit at once
    logic rate_meta_r;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_meta_r <= 1'b0;
            rate_r      <= 1'b0;
        end else begin
            rate_meta_r <= rate_fast;
            rate_r      <= rate_meta_r;
        end
    end

    // Period per rate; counts already scaled to ref_clk
    assign period   = rate_r ? CNT_W'(CONV_FAST) : CNT_W'(CONV_SLOW);
    assign stby_lim = rate_r ? CNT_W'(STBY_FAST) : CNT_W'(STBY_SLOW);
    // Countdown reaches one on the cycle a result is loaded
    assign conv_done = (conv_cnt_r == CNT_ONE);
    // Update interval precedes each new result; line driven high at its start
    assign update_win = (state_r == ST_RUN) && (conv_cnt_r <= CNT_W'(UPDATE_CYC));

    // Two's complement clip to the 24-bit extremes
    // Inputs beyond full scale stick at the extreme codes, never wrap
    always_comb begin
        if (sample_in > 32'sh007fffff) begin
            clipped = CODE_POS_MAX;
        end else if (sample_in < -32'sh00800000) begin
            clipped = CODE_NEG_MAX;
        end else begin
            clipped = sample_in[DATA_W-1:0];
        end
    end

    // Time held high for standby entry
    // Counting also runs while calibrating, but only RUN acts on it;
    // saturation keeps a very long high spell from wrapping to zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            high_cnt_r <= '0;
        end else if (!sclk_lvl || state_r == ST_STBY) begin
            high_cnt_r <= '0;
        end else if (high_cnt_r != '1) begin
            high_cnt_r <= high_cnt_r + CNT_ONE;
        end
    end

    // Mode sequencing and conversion countdown
    // A standby request wins over a calibration start in the same cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= ST_RUN;
            conv_cnt_r <= CNT_W'(CONV_SLOW);
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (sclk_lvl && high_cnt_r >= stby_lim) begin
                        state_r <= ST_STBY;
                    end else if (sclk_fall && bit_cnt_r == BIT_CAL_START) begin
                        state_r    <= ST_CAL;
                        conv_cnt_r <= rate_r ? CNT_W'(CAL_FAST) : CNT_W'(CAL_SLOW);
                    end else if (conv_done) begin
                        conv_cnt_r <= period;
                    end else begin
                        conv_cnt_r <= conv_cnt_r - CNT_ONE;
                    end
                end
                ST_CAL: begin
                    // Further clocks are tolerated while calibrating
                    if (conv_done) begin
                        state_r    <= ST_RUN;
                        conv_cnt_r <= period;
                    end else begin
                        conv_cnt_r <= conv_cnt_r - CNT_ONE;
                    end
                end
                ST_STBY: begin
                    // Edges are ignored here; only the low level wakes
                    if (!sclk_lvl) begin
                        state_r    <= ST_CAL;
                        conv_cnt_r <= rate_r ? CNT_W'(WAKE_FAST) : CNT_W'(WAKE_SLOW);
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // Inputs are off while calibrating or settling after wake
    assign cal_active = (state_r == ST_CAL);
    // Only standby powers the analog side down; the clock keeps running
    assign analog_on  = (state_r != ST_STBY);

    // Readout strobes shared by the counter, shifter and line processes
    assign load_result = conv_done && (state_r != ST_STBY);
    assign hold_end    = update_win && (conv_cnt_r == CNT_W'(UPDATE_CYC));
    assign shift_step  = sclk_rise && (bit_cnt_r != BIT_MAX) && !hold_end
                         && (state_r != ST_STBY);
    assign in_data     = (bit_cnt_r < 6'(DATA_W));

    // Edge counter; stops at its top so stray clocks cannot wrap it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_r <= '0;
        end else if (load_result) begin
            bit_cnt_r <= '0;
        end else if (shift_step) begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
        end
    end

    // Result shifter, most significant bit first
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shreg_r <= '0;
        end else if (load_result) begin
            shreg_r <= clipped;
        end else if (shift_step && in_data) begin
            shreg_r <= {shreg_r[DATA_W-2:0], 1'b0};
        end
    end

    // Ready/data line: low on a new result, then one bit per rising edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_r <= 1'b1;
        end else if (load_result) begin
            dout_r <= 1'b0;
        end else if (hold_end) begin
            dout_r <= 1'b1;                              // End of hold
        end else if (state_r == ST_STBY) begin
            dout_r <= 1'b1;
        end else if (shift_step) begin
            if (in_data) begin
                dout_r <= shreg_r[DATA_W-1];
            end else begin
                dout_r <= 1'b1;
            end
        end
    end

    // Pin driven straight from the flop so it never glitches
    assign link.ready_data_out = dout_r;
endmodule // adc_device

// [adc_host.sv]
`timescale 1ns/1ns
// Host end: polls ready, shifts result out, requests calibration or standby
module adc_host
    import adc_link_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    adc_link_if.host         link,
    input  wire logic        cal_req,
    input  wire logic        stby_req,
    output logic [DATA_W-1:0] result,
    output logic             result_valid,
    output logic             busy
);
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_HIGH  = 3'b001,
        H_LOW   = 3'b010,
        H_DONE  = 3'b011,
        H_STBY  = 3'b100,
        H_WAIT  = 3'b101
    } host_state_t;

    host_state_t       state_r;
    logic [7:0]        div_r;
    logic [5:0]        edges_r;
    logic [5:0]        target_r;
    logic [DATA_W-1:0] shreg_r;
    logic [DATA_W-1:0] result_r;
    logic              valid_r;
    logic              sclk_r;
    logic              rdy_meta_r;
    logic              rdy_r;
    logic              tick;

    // Ready line comes from outside: two flops
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdy_meta_r <= 1'b1;
            rdy_r      <= 1'b1;
        end else begin
            rdy_meta_r <= link.ready_data_out;
            rdy_r      <= rdy_meta_r;
        end
    end

    // Divider paces shift clock halves
    assign tick = (div_r == SCLK_HALF);
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= '0;
        end else if (tick || state_r == H_IDLE) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Shift sequence; each bit is taken at the end of the low half, after
    // the device answer has passed both input flops
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r  <= H_IDLE;
            sclk_r   <= 1'b0;
            edges_r  <= '0;
            target_r <= 6'(DATA_W);
            shreg_r  <= '0;
            result_r <= '0;
            valid_r  <= 1'b0;
        end else begin
            valid_r <= 1'b0;
            case (state_r)
                H_IDLE: begin
                    if (!rdy_r) begin
                        edges_r  <= '0;
                        target_r <= cal_req ? HOST_CAL_EDGES : 6'(DATA_W);
                        state_r  <= stby_req ? H_STBY : H_HIGH;
                        sclk_r   <= stby_req;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        if (edges_r != 6'h00 && edges_r <= 6'(DATA_W)) begin
                            shreg_r <= {shreg_r[DATA_W-2:0], rdy_r};
                        end
                        if (edges_r == target_r) begin
                            state_r <= H_DONE;
                        end else begin
                            sclk_r  <= 1'b1;
                            edges_r <= edges_r + 6'h01;
                            state_r <= H_LOW;
                        end
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        sclk_r  <= 1'b0;
                        state_r <= H_HIGH;
                    end
                end
                H_DONE: begin
                    result_r <= shreg_r;
                    valid_r  <= 1'b1;
                    state_r  <= H_WAIT;
                end
                H_WAIT: begin
                    // Wait for line high so one result is read once
                    if (rdy_r) begin
                        state_r <= H_IDLE;
                    end
                end
                H_STBY: begin
                    if (!stby_req) begin
                        sclk_r  <= 1'b0;
                        state_r <= H_IDLE;
                    end
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    assign link.shift_clk = sclk_r;
    assign result         = result_r;
    assign result_valid   = valid_r;
    assign busy           = (state_r != H_IDLE);
endmodule // adc_host

// [adc_link_chk.sv]
`timescale 1ns/1ns
// Link checks between the two ends
module adc_link_chk #(
    parameter int CAL  = 3000,
    parameter int WAKE = 2500,
    parameter int STBY = 1500
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic shift_clk,
    input wire logic ready_data_out
);
    localparam int TOL = 8;
    logic [5:0]  rise_cnt_r;
    logic [3:0]  idle_cnt_r;
    logic [31:0] hi_cnt_r;
    logic [31:0] wait_cnt_r;
    logic [31:0] wait_tgt_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Low spell length; eight quiet cycles close a frame
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst) idle_cnt_r <= 4'h0;
        else if (shift_clk) idle_cnt_r <= 4'h0;
        else if (idle_cnt_r != 4'h8) idle_cnt_r <= idle_cnt_r + 4'h1;
    // Rising edges within the current frame
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst) rise_cnt_r <= 6'h00;
        else if ($rose(shift_clk)) rise_cnt_r <= (idle_cnt_r == 4'h8) ? 6'h01 : rise_cnt_r + 6'h01;
        else if (idle_cnt_r == 4'h8) rise_cnt_r <= 6'h00;
    // High spell length, saturating so it cannot wrap in a long standby
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst) hi_cnt_r <= '0;
        else if (!shift_clk) hi_cnt_r <= '0;
        else if (hi_cnt_r < 32'(STBY + TOL)) hi_cnt_r <= hi_cnt_r + 32'h1;
    // Cycles from calibration start or wake-up until the line drops
    always_ff @(posedge ref_clk or posedge sys_rst)
        if (sys_rst) begin
            wait_cnt_r <= '0;
            wait_tgt_r <= '0;
        end else if ($fell(shift_clk) && rise_cnt_r == 6'h1a) begin
            wait_cnt_r <= 32'h1;
            wait_tgt_r <= 32'(CAL);
        end else if ($fell(shift_clk) && hi_cnt_r == 32'(STBY + TOL)) begin
            wait_cnt_r <= 32'h1;
            wait_tgt_r <= 32'(WAKE);
        end else if (!ready_data_out) wait_cnt_r <= '0;
        else if (wait_cnt_r != '0) wait_cnt_r <= wait_cnt_r + 32'h1;
    sequence s_edge25;
        $rose(shift_clk) && rise_cnt_r == 6'h18;
    endsequence
    sequence s_forced_high;
        ##[2:6] ready_data_out;
    endsequence
    property p_half_hi; $rose(shift_clk) |=> shift_clk [*2]; endproperty
    property p_half_lo; $fell(shift_clk) |=> !shift_clk [*2]; endproperty
    property p_ready_hold; $fell(ready_data_out) |=> !ready_data_out [*3]; endproperty
    property p_start_low; $rose(shift_clk) && rise_cnt_r == 6'h00 |-> !ready_data_out; endproperty
    property p_force_high; s_edge25 |-> s_forced_high; endproperty
    property p_stby_high; hi_cnt_r == 32'(STBY + TOL) |-> ready_data_out; endproperty
    property p_wait_early;
        wait_cnt_r != '0 && !ready_data_out |-> wait_cnt_r + 32'(TOL) >= wait_tgt_r;
    endproperty
    property p_wait_late; wait_cnt_r <= wait_tgt_r + 32'(TOL); endproperty
    a_half_hi: assert property (p_half_hi) else $error("shift clock high phase short");
    a_half_lo: assert property (p_half_lo) else $error("shift clock low phase short");
    a_ready_hold: assert property (p_ready_hold) else $error("ready low too short");
    a_start_low: assert property (p_start_low) else $error("shift began with line high");
    a_force_high: assert property (p_force_high) else $error("edge 25 left line low");
    a_stby_high: assert property (p_stby_high) else $error("line low in standby");
    a_wait_early: assert property (p_wait_early) else $error("ready came early");
    a_wait_late: assert property (p_wait_late) else $error("ready came late");
endmodule // adc_link_chk

// [adc_link_if.sv]
`timescale 1ns/1ns
// Two-wire link: host drives shift clock, device drives ready/data line
interface adc_link_if;
    logic shift_clk;
    logic ready_data_out;
    modport dev  (input shift_clk, output ready_data_out);
    modport host (output shift_clk, input ready_data_out);
endinterface // adc_link_if

// [adc_link_pkg.sv]
// Function
// - Continuous conversion; ready line low on result
// - Rising shift edges present MSB first
// - Extra edge after 24 bits forces high
// - Otherwise line holds last shifted bit
// - Host reads after low, within period
// - Host avoids clocks during update interval
// - Durations scale with conversion clock period (counts here are fixed at the nominal clock)
// - Host gives two extra clocks for calibration
// - 25th edge high; 26th fall starts calibration
// - Host keeps clocks minimal during calibration
// - Inputs disconnected, calibration signal applied
// - Calibration ends low with settled result
// - Host raises shift clock to request standby
// - Standby after shift clock held high
// - Standby powers down analog, clock kept
// - Host drops shift clock to wake
// - First result after wake at fixed delay
// - Result is 24-bit two's complement, clipped
// - Rate select picks slow or fast rate
package adc_link_pkg;
    localparam int    DATA_W       = 24;
    localparam int    CNT_W        = 32;
    localparam real   REF_CLK_MHZ  = 10.0;
    localparam real   CONV_CLK_MHZ = 4.9152;
    // Nominal durations at the nominal conversion clock, in microseconds
    localparam real   T_CONV_FAST_US   = 12500.0;
    localparam real   T_CONV_SLOW_US   = 100000.0;
    localparam real   T_UPDATE_US      = 39.0;
    localparam real   T_CAL_FAST_US    = 101280.0;
    localparam real   T_CAL_SLOW_US    = 801020.0;
    localparam real   T_STBY_FAST_US   = 12460.0;
    localparam real   T_STBY_SLOW_US   = 99960.0;
    localparam real   T_WAKE_FAST_US   = 52510.0;
    localparam real   T_WAKE_SLOW_US   = 401800.0;
    localparam real   T_ARM_FAST_US    = 12440.0;
    localparam real   T_ARM_SLOW_US    = 99940.0;
    // Derived counts of ref_clk cycles (least times round up)
    localparam int    CONV_FAST_CYC = int'($ceil(T_CONV_FAST_US * REF_CLK_MHZ));
    localparam int    CONV_SLOW_CYC = int'($ceil(T_CONV_SLOW_US * REF_CLK_MHZ));
    localparam int    UPDATE_CYC    = int'($ceil(T_UPDATE_US * REF_CLK_MHZ));
    localparam int    CAL_FAST_CYC  = int'($ceil(T_CAL_FAST_US * REF_CLK_MHZ));
    localparam int    CAL_SLOW_CYC  = int'($ceil(T_CAL_SLOW_US * REF_CLK_MHZ));
    localparam int    STBY_FAST_CYC = int'($ceil(T_STBY_FAST_US * REF_CLK_MHZ));
    localparam int    STBY_SLOW_CYC = int'($ceil(T_STBY_SLOW_US * REF_CLK_MHZ));
    localparam int    WAKE_FAST_CYC = int'($ceil(T_WAKE_FAST_US * REF_CLK_MHZ));
    localparam int    WAKE_SLOW_CYC = int'($ceil(T_WAKE_SLOW_US * REF_CLK_MHZ));
    localparam int    ARM_FAST_CYC  = int'($floor(T_ARM_FAST_US * REF_CLK_MHZ));
    localparam int    ARM_SLOW_CYC  = int'($floor(T_ARM_SLOW_US * REF_CLK_MHZ));
    localparam logic [5:0] BIT_CAL_HIGH  = 6'h19;  // 25th edge
    localparam logic [5:0] BIT_CAL_START = 6'h1a;  // 26th edge
    localparam logic [5:0] BIT_MAX       = 6'h3f;
    localparam logic [DATA_W-1:0] CODE_POS_MAX = 24'h7fffff;
    localparam logic [DATA_W-1:0] CODE_NEG_MAX = 24'h800000;
    localparam logic [CNT_W-1:0]  CNT_ONE      = 32'h00000001;
    localparam logic [7:0]        SCLK_HALF    = 8'h02;    // Host shift half period
    localparam logic [5:0]        HOST_CAL_EDGES = 6'h1a;
endpackage

// [adc_serial_readout_cal_standby_test.sv]
`timescale 1ns/1ns
// Both ends joined over the link; user sides driven and checked here
module adc_serial_readout_cal_standby_test;
    import adc_link_pkg::*;
    localparam int CONV_F = 2000;
    localparam int CONV_S = 4000;
    localparam int CAL_N  = 3000;
    localparam int STBY_N = 1500;
    localparam int WAKE_N = 2500;
    typedef struct {
        logic signed [31:0] smp;
        logic               fast;
        logic [DATA_W-1:0]  exp;
    } row_t;
    row_t rows [6] = '{
        '{32'sh00123456, 1'b1, 24'h123456}, '{32'shffffffff, 1'b1, 24'hffffff},
        '{32'sh00800000, 1'b1, 24'h7fffff}, '{32'shff800000, 1'b0, 24'h800000},
        '{32'sh80000000, 1'b0, 24'h800000}, '{32'sh7fffffff, 1'b1, 24'h7fffff}};
    logic               ref_clk;
    logic               sys_rst;
    logic               rate_fast;
    logic signed [31:0] sample_in;
    logic               cal_req;
    logic               stby_req;
    logic [DATA_W-1:0]  result;
    logic               result_valid;
    logic               busy;
    logic               cal_active;
    logic               analog_on;
    int                 n_mismatch;
    int                 n_checks;
    int                 cyc;
    int                 gap;
    adc_link_if link_bus ();
    adc_device #(.CONV_FAST(CONV_F), .CONV_SLOW(CONV_S), .CAL_FAST(CAL_N), .CAL_SLOW(CAL_N),
        .STBY_FAST(STBY_N), .STBY_SLOW(STBY_N), .WAKE_FAST(WAKE_N), .WAKE_SLOW(WAKE_N))
    i_adc_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link_bus), .rate_fast(rate_fast),
        .sample_in(sample_in), .cal_active(cal_active), .analog_on(analog_on));
    adc_host i_adc_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link_bus), .cal_req(cal_req),
        .stby_req(stby_req), .result(result), .result_valid(result_valid), .busy(busy));
    adc_link_chk #(.CAL(CAL_N), .WAKE(WAKE_N), .STBY(STBY_N)) i_adc_link_chk (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .shift_clk(link_bus.shift_clk),
        .ready_data_out(link_bus.ready_data_out));
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk24(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask
    // Sampling just after each edge sees every one-cycle result pulse once
    task automatic wait_valid(input int lim, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (result_valid !== 1'b1 && n < lim);
        chk1("result_valid", 1'b1, result_valid);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Hang guard sized well above the planned sequence
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        sys_rst = 1'b1;
        rate_fast = 1'b1;
        sample_in = 32'sh0;
        cal_req = 1'b0;
        stby_req = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        // Hold each sample over two conversions and take the second result
        foreach (rows[i]) begin
            sample_in = rows[i].smp;
            rate_fast = rows[i].fast;
            wait_valid(3 * CONV_S, gap);
            wait_valid(CONV_S + 400, gap);
            chk24("result", rows[i].exp, result);
            chk1("period", 1'b1, gap > (rows[i].fast ? CONV_F : CONV_S) - 50 && gap < (rows[i].fast ? CONV_F : CONV_S) + 50);
            repeat (40) @(posedge ref_clk);
            #1;
            chk1("line_hold", rows[i].exp[0], link_bus.ready_data_out);
        end
        // Calibration requested with two extra clocks after a read
        sample_in = 32'sh000abcde;
        cal_req = 1'b1;
        wait_valid(2 * CONV_F, gap);
        cal_req = 1'b0;
        repeat (40) @(posedge ref_clk);
        chk1("line_forced", 1'b1, link_bus.ready_data_out);
        chk1("cal_active", 1'b1, cal_active);
        wait_valid(CAL_N + 400, gap);
        chk1("cal_time", 1'b1, gap > CAL_N - 100);
        chk24("cal_result", 24'h0abcde, result);
        // Standby: clock held high after ready, dropped later to wake
        stby_req = 1'b1;
        gap = 0;
        while (analog_on !== 1'b0 && gap < CONV_F + STBY_N + 400) begin
            @(posedge ref_clk);
            #1;
            gap++;
        end
        chk1("analog_off", 1'b0, analog_on);
        repeat (200) @(posedge ref_clk);
        #1;
        chk1("line_stby", 1'b1, link_bus.ready_data_out);
        chk1("still_off", 1'b0, analog_on);
        stby_req = 1'b0;
        wait_valid(WAKE_N + 400, gap);
        chk1("wake_time", 1'b1, gap > WAKE_N - 100);
        chk1("analog_on", 1'b1, analog_on);
        chk24("wake_result", 24'h0abcde, result);
        // Reset in mid-read; the next read must start again at the top bit
        sample_in = 32'shfff00001;
        gap = 0;
        while (link_bus.shift_clk !== 1'b1 && gap < 3 * CONV_F) begin
            @(posedge ref_clk);
            #1;
            gap++;
        end
        chk1("busy", 1'b1, busy);
        repeat (20) @(posedge ref_clk);
        #1;
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk1("rst_clk", 1'b0, link_bus.shift_clk);
        chk1("rst_line", 1'b1, link_bus.ready_data_out);
        sys_rst = 1'b0;
        wait_valid(3 * CONV_S, gap);
        wait_valid(CONV_S + 400, gap);
        chk24("rst_result", 24'hf00001, result);
        tally_and_finish();
    end
endmodule // adc_serial_readout_cal_standby_test

// [sync_edge.sv]
`timescale 1ns/1ns
// Two-flop synchroniser with rise and fall detect on the second stage
module sync_edge (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // Only sync_r reads meta_r
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~last_r;
    assign fall  = ~sync_r & last_r;
endmodule // sync_edge
